//--- logic/crv_regs.v
// Rate, volume and digital-out control registers of the audio codec,
// reached over APB, driving converter rates, channel levels and the
// digital-out slot picker.
// Assumes one clock, APB master in the same domain, link slots already
// deserialised and presented with a one-cycle frame strobe.
`timescale 1ns/100ps
`default_nettype none
`include "crv_consts.vh"

module crv_regs
#(
  parameter SW = 20
)
(
  // Clock and reset
  input  wire          clock,
  input  wire          rst_n,
  input  wire          ce,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output wire          pready,
  output reg  [31:0]   prdata_ff,
  output wire          pslverr,
  // Link slots
  input  wire          frameStrobe,
  input  wire [SW-1:0] slot3,
  input  wire [SW-1:0] slot4,
  input  wire [SW-1:0] slot6,
  input  wire [SW-1:0] slot7,
  input  wire [SW-1:0] slot8,
  input  wire [SW-1:0] slot9,
  input  wire [SW-1:0] slot10,
  input  wire [SW-1:0] slot11,
  // Digital-out transmitter
  output wire [SW-1:0] spdifLeft,
  output wire [SW-1:0] spdifRight,
  output wire          spdifValid,
  output wire          spdifTxEnable,
  output wire          doubleRateEnable,
  // Converter rates in hertz
  output reg  [15:0]   dacRate_ff,
  output reg  [15:0]   adcRate_ff,
  // Channel levels in half dB and mutes
  output wire [6:0]    centerAtten,
  output wire          centerMute,
  output wire [6:0]    lfeAtten,
  output wire          lfeMute,
  output wire [6:0]    leftRearAtten,
  output wire          leftRearMute,
  output wire [6:0]    rightRearAtten,
  output wire          rightRearMute,
  output wire          altLineRouting
);

  // Storage
  reg        variableRateEnable_ff;
  reg        doubleRateEnable_ff;
  reg        spdifEnable_ff;
  reg [1:0]  spdifSourceSelect_ff;
  reg [15:0] frontRate_ff;
  reg [15:0] adcRateReg_ff;
  reg [15:0] centerLfeVol_ff;
  reg [15:0] surroundVol_ff;
  reg        altRouting_ff;
  reg        loaded_ff;

  reg [31:0] nxt_prdata;
  reg        hit;

  wire [7:0] regIndex = paddr[9:2];
  wire       accessOk = psel & penable;
  wire       doneCycle = accessOk & pready;
  wire       writeDone = doneCycle & pwrite & hit;

  // Byte-lane merge of a 16-bit register
  function [15:0] mergeStrb;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  st;
    begin
      mergeStrb[7:0]  = st[0] ? wd[7:0]  : old[7:0];
      mergeStrb[15:8] = st[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // Read decode; unmapped or misaligned addresses miss
  always @*
  begin
    nxt_prdata = 32'h00000000;
    hit        = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (regIndex)
      `CRV_IDX_EXT_CTRL:
      begin
        nxt_prdata[`CRV_EXT_VRA_BIT]   = variableRateEnable_ff;
        nxt_prdata[`CRV_EXT_DRA_BIT]   = doubleRateEnable_ff;
        nxt_prdata[`CRV_EXT_SPDIF_BIT] = spdifEnable_ff;
        nxt_prdata[`CRV_EXT_SSA_HI:`CRV_EXT_SSA_LO] = spdifSourceSelect_ff;
      end
      // Alias reads mirror the front rate
      `CRV_IDX_FRONT_RATE,
      `CRV_IDX_SURR_RATE,
      `CRV_IDX_LFE_RATE:
        nxt_prdata[15:0] = frontRate_ff;
      `CRV_IDX_ADC_RATE:
        nxt_prdata[15:0] = adcRateReg_ff;
      `CRV_IDX_CLFE_VOL:
        nxt_prdata[15:0] = centerLfeVol_ff;
      `CRV_IDX_SURR_VOL:
        nxt_prdata[15:0] = surroundVol_ff;
      `CRV_IDX_VENDOR:
        nxt_prdata[`CRV_VEND_ALT_BIT] = altRouting_ff;
      default:
        hit = 1'b0;
    endcase
  end

  // One wait state: read data is latched on the same edge that raises pready
  assign pready  = ce & loaded_ff;
  assign pslverr = accessOk & pready & ~hit;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loaded_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else if (ce)
    begin
      if (doneCycle)
        loaded_ff <= 1'b0;
      else if (accessOk)
      begin
        loaded_ff <= 1'b1;
        prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
      end
    end
  end

  // Register writes
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      variableRateEnable_ff <= 1'b0;
      doubleRateEnable_ff   <= 1'b0;
      spdifEnable_ff        <= 1'b0;
      spdifSourceSelect_ff  <= `CRV_SSA_RESET;
      frontRate_ff          <= `CRV_RATE_RESET;
      adcRateReg_ff         <= `CRV_RATE_RESET;
      centerLfeVol_ff       <= `CRV_VOL_RESET;
      surroundVol_ff        <= `CRV_VOL_RESET;
      altRouting_ff         <= `CRV_ALT_RESET;
    end
    else if (ce & writeDone)
    begin
      case (regIndex)
        `CRV_IDX_EXT_CTRL:
        begin
          if (pstrb[0])
          begin
            variableRateEnable_ff <= pwdata[`CRV_EXT_VRA_BIT];
            doubleRateEnable_ff   <= pwdata[`CRV_EXT_DRA_BIT];
            spdifEnable_ff        <= pwdata[`CRV_EXT_SPDIF_BIT];
            spdifSourceSelect_ff  <=
              pwdata[`CRV_EXT_SSA_HI:`CRV_EXT_SSA_LO];
          end
        end
        `CRV_IDX_FRONT_RATE:
          frontRate_ff <= mergeStrb(frontRate_ff, pwdata[15:0],
                                    pstrb[1:0]);
        // ADC rate kept apart from DAC rate
        `CRV_IDX_ADC_RATE:
          adcRateReg_ff <= mergeStrb(adcRateReg_ff, pwdata[15:0],
                                     pstrb[1:0]);
        `CRV_IDX_CLFE_VOL:
          centerLfeVol_ff <= mergeStrb(centerLfeVol_ff, pwdata[15:0],
                                       pstrb[1:0]);
        `CRV_IDX_SURR_VOL:
          surroundVol_ff <= mergeStrb(surroundVol_ff, pwdata[15:0],
                                      pstrb[1:0]);
        `CRV_IDX_VENDOR:
        begin
          if (pstrb[1])
            altRouting_ff <= pwdata[`CRV_VEND_ALT_BIT];
        end
        default:
          altRouting_ff <= altRouting_ff;
      endcase
    end
  end

  // Effective converter rates
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dacRate_ff <= `CRV_FIXED_RATE;
      adcRate_ff <= `CRV_FIXED_RATE;
    end
    else if (ce)
    begin
      // Fixed 48 kHz unless variable rate is on
      // One rate for all six DAC channels
      dacRate_ff <= variableRateEnable_ff ? frontRate_ff
                                          : `CRV_FIXED_RATE;
      adcRate_ff <= variableRateEnable_ff ? adcRateReg_ff
                                          : `CRV_FIXED_RATE;
    end
  end

  assign spdifTxEnable    = spdifEnable_ff;
  assign doubleRateEnable = doubleRateEnable_ff;
  assign altLineRouting   = altRouting_ff;

  // Center in low half, LFE in high half
  crv_atten uCenter
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .ce             (ce),
    .levelCode      (centerLfeVol_ff[`CRV_VOL_LO_MSB:`CRV_VOL_LO_LSB]),
    .muteBit        (centerLfeVol_ff[`CRV_VOL_MUTE_LO]),
    .bypass         (1'b0),
    .attenHalfDb_ff (centerAtten),
    .muted_ff       (centerMute)
  );

  crv_atten uLfe
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .ce             (ce),
    .levelCode      (centerLfeVol_ff[`CRV_VOL_HI_MSB:`CRV_VOL_HI_LSB]),
    .muteBit        (centerLfeVol_ff[`CRV_VOL_MUTE_HI]),
    .bypass         (1'b0),
    .attenHalfDb_ff (lfeAtten),
    .muted_ff       (lfeMute)
  );

  // Left rear high half, right rear low half
  // Bypassed while alternate routing owns the pins
  crv_atten uLeftRear
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .ce             (ce),
    .levelCode      (surroundVol_ff[`CRV_VOL_HI_MSB:`CRV_VOL_HI_LSB]),
    .muteBit        (surroundVol_ff[`CRV_VOL_MUTE_HI]),
    .bypass         (altRouting_ff),
    .attenHalfDb_ff (leftRearAtten),
    .muted_ff       (leftRearMute)
  );

  crv_atten uRightRear
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .ce             (ce),
    .levelCode      (surroundVol_ff[`CRV_VOL_LO_MSB:`CRV_VOL_LO_LSB]),
    .muteBit        (surroundVol_ff[`CRV_VOL_MUTE_LO]),
    .bypass         (altRouting_ff),
    .attenHalfDb_ff (rightRearAtten),
    .muted_ff       (rightRearMute)
  );

  crv_slot_sel #(.SW(SW)) uSlotSel
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .ce             (ce),
    .txEnable       (spdifEnable_ff),
    .sourceSelect   (spdifSourceSelect_ff),
    .frameStrobe    (frameStrobe),
    .slot3          (slot3),
    .slot4          (slot4),
    .slot6          (slot6),
    .slot7          (slot7),
    .slot8          (slot8),
    .slot9          (slot9),
    .slot10         (slot10),
    .slot11         (slot11),
    .leftData_ff    (spdifLeft),
    .rightData_ff   (spdifRight),
    .sampleValid_ff (spdifValid)
  );

endmodule // crv_regs
`default_nettype wire

//--- logic/crv_consts.vh
// Constants of the codec rate, volume and digital-out register bank.
// Included by the register bank and its helper modules; no logic here.
`ifndef CRV_CONSTS_VH
`define CRV_CONSTS_VH

// Register indices; byte address on APB is four times the index
`define CRV_IDX_EXT_CTRL      8'h2A
`define CRV_IDX_FRONT_RATE    8'h2C
`define CRV_IDX_SURR_RATE     8'h2E
`define CRV_IDX_LFE_RATE      8'h30
`define CRV_IDX_ADC_RATE      8'h32
`define CRV_IDX_CLFE_VOL      8'h36
`define CRV_IDX_SURR_VOL      8'h38
`define CRV_IDX_VENDOR        8'h5A

// Extended status/control fields
`define CRV_EXT_VRA_BIT       0
`define CRV_EXT_DRA_BIT       1
`define CRV_EXT_SPDIF_BIT     2
`define CRV_EXT_SSA_LO        4
`define CRV_EXT_SSA_HI        5

// Volume register fields
`define CRV_VOL_MUTE_HI       15
`define CRV_VOL_HI_MSB        12
`define CRV_VOL_HI_LSB        8
`define CRV_VOL_MUTE_LO       7
`define CRV_VOL_LO_MSB        4
`define CRV_VOL_LO_LSB        0

// Vendor register: alternate line level routing
`define CRV_VEND_ALT_BIT      15

// Reset values
`define CRV_RATE_RESET        16'hBB80
`define CRV_FIXED_RATE        16'hBB80
`define CRV_VOL_RESET         16'h8080
`define CRV_ALT_RESET         1'h1
`define CRV_SSA_RESET         2'h0

// Half-dB units per attenuation step (1.5 dB)
`define CRV_HALFDB_PER_STEP   7'h03

// Source slot pair selections
`define CRV_SSA_SLOT34        2'h0
`define CRV_SSA_SLOT78        2'h1
`define CRV_SSA_SLOT69        2'h2
`define CRV_SSA_SLOT1011      2'h3

`endif

//--- logic/crv_atten.v
// One output channel's attenuation and mute stage.
// Expects level code and mute bit straight from a volume register.
`timescale 1ns/100ps
`default_nettype none
`include "crv_consts.vh"

module crv_atten
(
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  input  wire       ce,
  // Settings
  input  wire [4:0] levelCode,
  input  wire       muteBit,
  input  wire       bypass,
  // Result
  output reg  [6:0] attenHalfDb_ff,
  output reg        muted_ff
);

  reg [6:0] nxt_attenHalfDb;
  reg       nxt_muted;

  always @*
  begin
    // Code zero is 0 dB, each step adds 1.5 dB
    // 31 steps down to 46.5 dB, counted in half dB
    nxt_attenHalfDb = {2'h0, levelCode} * `CRV_HALFDB_PER_STEP;
    nxt_muted       = muteBit;
    // Routed away: register has no say on these pins
    if (bypass)
    begin
      nxt_attenHalfDb = 7'h00;
      nxt_muted       = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      attenHalfDb_ff <= 7'h00;
      muted_ff       <= 1'b1;
    end
    else if (ce)
    begin
      attenHalfDb_ff <= nxt_attenHalfDb;
      muted_ff       <= nxt_muted;
    end
  end

endmodule // crv_atten
`default_nettype wire

//--- logic/crv_slot_sel.v
// Picks the digital-out sample pair from the incoming link slots.
// Slot words and frame strobe come from the link receiver, one clock.
`timescale 1ns/100ps
`default_nettype none
`include "crv_consts.vh"

module crv_slot_sel
#(
  parameter SW = 20
)
(
  // Clock and reset
  input  wire          clock,
  input  wire          rst_n,
  input  wire          ce,
  // Control
  input  wire          txEnable,
  input  wire [1:0]    sourceSelect,
  // Link slots, valid on frameStrobe
  input  wire          frameStrobe,
  input  wire [SW-1:0] slot3,
  input  wire [SW-1:0] slot4,
  input  wire [SW-1:0] slot6,
  input  wire [SW-1:0] slot7,
  input  wire [SW-1:0] slot8,
  input  wire [SW-1:0] slot9,
  input  wire [SW-1:0] slot10,
  input  wire [SW-1:0] slot11,
  // Transmitter samples
  output reg  [SW-1:0] leftData_ff,
  output reg  [SW-1:0] rightData_ff,
  output reg           sampleValid_ff
);

  reg [SW-1:0] nxt_left;
  reg [SW-1:0] nxt_right;

  // Slot pair chosen by source select
  always @*
  begin
    case (sourceSelect)
      `CRV_SSA_SLOT34:
      begin
        nxt_left  = slot3;
        nxt_right = slot4;
      end
      `CRV_SSA_SLOT78:
      begin
        nxt_left  = slot7;
        nxt_right = slot8;
      end
      `CRV_SSA_SLOT69:
      begin
        nxt_left  = slot6;
        nxt_right = slot9;
      end
      default:
      begin
        nxt_left  = slot10;
        nxt_right = slot11;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      leftData_ff    <= {SW{1'b0}};
      rightData_ff   <= {SW{1'b0}};
      sampleValid_ff <= 1'b0;
    end
    else if (ce)
    begin
      sampleValid_ff <= frameStrobe & txEnable;
      if (frameStrobe & txEnable)
      begin
        leftData_ff  <= nxt_left;
        rightData_ff <= nxt_right;
      end
    end
  end

endmodule // crv_slot_sel
`default_nettype wire

//--- sim/crv_checker.sv
// Port assertions for the codec rate, volume and digital-out bank.
// Bound into crv_regs; one clock domain, sees the top ports only.
`timescale 1ns/100ps
`default_nettype none

module crv_checker
#(
  parameter int SW = 20
)
(
  // Clock and reset
  input wire logic          clock,
  input wire logic          rst_n,
  input wire logic          ce,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic          pready,
  // Link slots and transmitter
  input wire logic          frameStrobe,
  input wire logic [SW-1:0] slot3,
  input wire logic [SW-1:0] slot4,
  input wire logic [SW-1:0] slot6,
  input wire logic [SW-1:0] slot7,
  input wire logic [SW-1:0] slot8,
  input wire logic [SW-1:0] slot9,
  input wire logic [SW-1:0] slot10,
  input wire logic [SW-1:0] slot11,
  input wire logic [SW-1:0] spdifLeft,
  input wire logic [SW-1:0] spdifRight,
  input wire logic          spdifValid,
  input wire logic          spdifTxEnable,
  // Rates and levels
  input wire logic [15:0]   dacRate_ff,
  input wire logic [15:0]   adcRate_ff,
  input wire logic [6:0]    centerAtten,
  input wire logic [6:0]    lfeAtten,
  input wire logic [6:0]    leftRearAtten,
  input wire logic [6:0]    rightRearAtten,
  input wire logic          leftRearMute,
  input wire logic          rightRearMute,
  input wire logic          altLineRouting
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  wire wrDone = psel && penable && pready && pwrite;

  sequence frameTaken;
    frameStrobe && spdifTxEnable && ce;
  endsequence

  sequence aliasWrite;
    wrDone && (paddr == 12'h0B8 || paddr == 12'h0C0);
  endsequence

  tx_pulse_a:
    assert property (frameTaken |=> spdifValid)
    else $error("enabled frame gave no output pulse");
  tx_gate_a:
    assert property (spdifValid |-> $past(frameStrobe && spdifTxEnable))
    else $error("output pulse without enabled frame");
  pair_pick_a:
    assert property (spdifValid |->
      {spdifLeft, spdifRight} == $past({slot3, slot4})
      || {spdifLeft, spdifRight} == $past({slot7, slot8})
      || {spdifLeft, spdifRight} == $past({slot6, slot9})
      || {spdifLeft, spdifRight} == $past({slot10, slot11}))
    else $error("output pair from no allowed slots");
  reset_rate_a:
    assert property (!$past(rst_n) |->
      dacRate_ff == 16'hBB80 && adcRate_ff == 16'hBB80)
    else $error("rates not 48000 after reset");
  rate_hold_a:
    assert property (!$past(wrDone) && !$past(wrDone, 2) |->
      $stable(dacRate_ff) && $stable(adcRate_ff))
    else $error("rate moved without a write");
  alias_keep_a:
    assert property (aliasWrite |=> $stable(dacRate_ff) [*2])
    else $error("alias write moved the DAC rate");
  atten_step_a:
    assert property (centerAtten % 3 == 0 && lfeAtten % 3 == 0
      && leftRearAtten % 3 == 0 && rightRearAtten % 3 == 0
      && centerAtten <= 7'd93 && lfeAtten <= 7'd93
      && leftRearAtten <= 7'd93 && rightRearAtten <= 7'd93)
    else $error("attenuation off the 1.5 dB grid");
  rear_bypass_a:
    assert property (altLineRouting && $past(altLineRouting)
      && $past(altLineRouting, 2) && $past(rst_n, 2) |->
      leftRearAtten == 7'd0 && rightRearAtten == 7'd0
      && !leftRearMute && !rightRearMute)
    else $error("rear levels act while routed to line out");
endmodule // crv_checker

bind crv_regs crv_checker #(.SW(SW)) chk_u (.*);

`default_nettype wire

//--- sim/crv_link_model.sv
// Controller-side stand-in: slot words with a one-cycle frame strobe.
// Assumes the bench calls send right after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module crv_link_model
#(
  parameter int SW = 20
)
(
  // Clock
  input  wire logic          clock,
  // Frame strobe and slot words
  output var  logic          frameStrobe,
  output wire logic [SW-1:0] slot3,
  output wire logic [SW-1:0] slot4,
  output wire logic [SW-1:0] slot6,
  output wire logic [SW-1:0] slot7,
  output wire logic [SW-1:0] slot8,
  output wire logic [SW-1:0] slot9,
  output wire logic [SW-1:0] slot10,
  output wire logic [SW-1:0] slot11
);
  logic [SW-1:0] s [0:11];

  assign slot3 = s[3];
  assign slot4 = s[4];
  assign slot6 = s[6];
  assign slot7 = s[7];
  assign slot8 = s[8];
  assign slot9 = s[9];
  assign slot10 = s[10];
  assign slot11 = s[11];

  initial
  begin
    frameStrobe = 1'b0;
    foreach (s[i]) s[i] = '0;
  end

  task automatic send(input logic [7:0] tag);
    @(posedge clock);
    frameStrobe <= 1'b1;
    foreach (s[i]) s[i] <= SW'({tag, 4'(i), 8'hC3});
    @(posedge clock);
    frameStrobe <= 1'b0;
    // Words not held past the frame, so a stale capture shows
    foreach (s[i]) s[i] <= ~s[i];
  endtask
endmodule // crv_link_model

`default_nettype wire

//--- sim/tb_codec_rate_volume_regs.sv
// Self-checking bench of the rate, volume and digital-out registers.
// Drives APB itself; the link model supplies the slot frames.
`timescale 1ns/100ps
`default_nettype none

module tb_codec_rate_volume_regs;
  localparam int SW = 20;
  localparam int LS [4] = '{3, 7, 6, 10};
  localparam int RS [4] = '{4, 8, 9, 11};
  // Write flag, byte address, write data, expected read-back
  localparam logic [44:0] ROWS [17] = '{
    {1'b0, 12'h0A8, 16'h0000, 16'h0000},
    {1'b0, 12'h0B0, 16'h0000, 16'hBB80},
    {1'b0, 12'h0B8, 16'h0000, 16'hBB80},
    {1'b0, 12'h0C0, 16'h0000, 16'hBB80},
    {1'b0, 12'h0C8, 16'h0000, 16'hBB80},
    {1'b0, 12'h0D8, 16'h0000, 16'h8080},
    {1'b0, 12'h0E0, 16'h0000, 16'h8080},
    {1'b0, 12'h168, 16'h0000, 16'h8000},
    {1'b1, 12'h0B0, 16'h1F40, 16'h1F40},
    {1'b1, 12'h0B8, 16'h1234, 16'h1F40},
    {1'b1, 12'h0C0, 16'hFFFF, 16'h1F40},
    {1'b1, 12'h0C8, 16'h3E80, 16'h3E80},
    {1'b0, 12'h0B0, 16'h0000, 16'h1F40},
    {1'b1, 12'h0D8, 16'h8A05, 16'h8A05},
    {1'b1, 12'h0E0, 16'h1F80, 16'h1F80},
    {1'b1, 12'h0A8, 16'h0003, 16'h0003},
    {1'b1, 12'h0B0, 16'hFFFF, 16'hFFFF}
  };

  logic          clock, rst_n, ce, psel, penable, pwrite, frameStrobe;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata_ff, rd;
  logic [3:0]    pstrb;
  logic          pready, pslverr, err, spdifValid, spdifTxEnable;
  logic          doubleRateEnable, altLineRouting;
  logic [SW-1:0] slot3, slot4, slot6, slot7, slot8, slot9, slot10, slot11;
  logic [SW-1:0] spdifLeft, spdifRight;
  logic [15:0]   dacRate_ff, adcRate_ff;
  logic [6:0]    centerAtten, lfeAtten, leftRearAtten, rightRearAtten;
  logic          centerMute, lfeMute, leftRearMute, rightRearMute;
  int            failures, cmpCount;

  crv_regs #(.SW(SW)) dut_u (.*);
  crv_link_model #(.SW(SW)) link_u (.*);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Ends an idle cycle after completion so lagging outputs have settled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata_ff;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    failures++;
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    cmpCount = 0;
    ce = 1'b1;
    pstrb = 4'h3;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i][44])
        apb(1'b1, ROWS[i][43:32], ROWS[i][31:16]);
      apb(1'b0, ROWS[i][43:32], 16'h0000);
      chk(rd, {16'h0000, ROWS[i][15:0]});
    end
    chk(32'(dacRate_ff), 32'hFFFF);
    chk(32'(adcRate_ff), 32'h3E80);
    chk(32'(doubleRateEnable), 32'h1);
    chk(32'({lfeMute, lfeAtten, centerMute, centerAtten}),
        32'({1'b1, 7'd30, 1'b0, 7'd15}));
    chk(32'({leftRearMute, leftRearAtten, rightRearMute, rightRearAtten}),
        32'h0);
    apb(1'b1, 12'h168, 16'h0000);
    chk(32'({leftRearMute, leftRearAtten, rightRearMute, rightRearAtten}),
        32'({1'b0, 7'd93, 1'b1, 7'd0}));
    link_u.send(8'h11);
    #1;
    chk(32'(spdifValid), 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 12'h0A8, 16'(4 + 16 * s));
      link_u.send(8'(s));
      #1;
      chk(32'({spdifTxEnable, spdifValid}), 32'h3);
      chk(32'(spdifLeft), 32'({8'(s), 4'(LS[s]), 8'hC3}));
      chk(32'(spdifRight), 32'({8'(s), 4'(RS[s]), 8'hC3}));
    end
    chk(32'({dacRate_ff, adcRate_ff}), 32'hBB80BB80);
    // Misaligned: error flag, data still decoded from the index
    apb(1'b0, 12'h0B2, 16'h0000);
    chk({rd[30:0], err}, 32'h0001FFFF);
    // Unmapped aligned index: error flag, nothing read
    apb(1'b0, 12'h0A0, 16'h0000);
    chk({rd[30:0], err}, 32'h1);
    // Frozen clock enable: frame ignored, last pair kept
    @(posedge clock);
    ce <= 1'b0;
    link_u.send(8'h77);
    #1;
    chk(32'({spdifValid, spdifLeft}),
        32'({1'b0, 8'h03, 4'hA, 8'hC3}));
    @(posedge clock);
    ce <= 1'b1;
    // Mid-run reset returns every default
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    chk(32'({spdifTxEnable, altLineRouting, dacRate_ff}),
        32'({1'b0, 1'b1, 16'hBB80}));
    chk(32'({centerMute, lfeMute, leftRearMute, rightRearMute, adcRate_ff}),
        32'({4'hF, 16'hBB80}));
    @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 12'h0B0, 16'h0000);
    chk(rd, 32'h0000BB80);
    stop_test();
  end
endmodule // tb_codec_rate_volume_regs

`default_nettype wire
